//--- dtt_pkg.sv
// Shared constants, field layouts and enumerations of the debug trace and trigger unit
`default_nettype none
package dtt_pkg;
    // Clock and time base
    localparam int CLK_PERIOD_PS = 8000;
    localparam int TS_RES_PS     = 8333;
    localparam int TS_W          = 48;
    localparam logic [13:0] TS_STEP = 14'(CLK_PERIOD_PS);
    localparam logic [13:0] TS_RES  = 14'(TS_RES_PS);
    localparam int US_NS         = 1000;
    localparam int US_CYC        = (US_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SUPP_NS       = 10000;
    localparam int SUPP_CYC      = (SUPP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int EXEC_RES_PS   = 90900;
    // Trace queue and probe memory
    localparam int QDEPTH        = 8;
    localparam logic [3:0] QOVF_LEVEL = 4'h7;
    localparam logic [3:0] QFULL      = 4'h8;
    localparam int MEM_AW        = 10;
    localparam logic [MEM_AW-1:0] MEM_LAST = 10'h3ff;
    localparam int ENTRY_W       = 2 + 32 + 32 + TS_W;
    // Run-time monitor window
    localparam logic [31:0] LRAM_BASE  = 32'h1000_0000;
    localparam logic [31:0] LRAM_LIMIT = 32'h1000_ffff;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_TCFG    = 8'h04;
    localparam logic [7:0] OFS_PWIDTH  = 8'h08;
    localparam logic [7:0] OFS_STARTUP = 8'h0c;
    localparam logic [7:0] OFS_STATUS  = 8'h10;
    localparam logic [7:0] OFS_TS_LO   = 8'h14;
    localparam logic [7:0] OFS_TS_HI   = 8'h18;
    localparam logic [7:0] OFS_EXEC    = 8'h1c;
    localparam logic [7:0] OFS_MON     = 8'h20;
    // Control fields
    localparam int CTRL_CAP      = 0;
    localparam int CTRL_TS       = 1;
    localparam int CTRL_RUN      = 2;
    localparam int CTRL_POL_LO   = 3;
    localparam int CTRL_PBRK     = 5;
    localparam logic [31:0] CTRL_MASK = 32'h0000_003f;
    // Trigger configuration fields, one byte per input channel, output bits above
    localparam int TCFG_MODE_LO  = 0;
    localparam int TCFG_IN_EN    = 3;
    localparam int TCFG_ACT_STOP = 4;
    localparam int TCFG_STRIDE   = 8;
    localparam int TCFG_OUT_EN   = 16;
    localparam int TCFG_OUT_POL  = 17;
    localparam int TCFG_OSTRIDE  = 2;
    localparam logic [31:0] TCFG_MASK = 32'h000f_1f1f;
    // Status fields
    localparam int ST_REC        = 0;
    localparam int ST_FULL       = 1;
    localparam int ST_OVF        = 2;
    localparam int ST_MONERR     = 3;
    localparam int ST_TSRUN      = 4;
    localparam int ST_CNT_LO     = 8;
    localparam int ST_ADDR_LO    = 16;
    // Reset values
    localparam logic [31:0] RST_PWIDTH = 32'h0001_0001;
    localparam logic [31:0] RST_ZERO   = 32'h0000_0000;

    typedef enum logic [1:0] {
        DTT_KIND_PC  = 2'h0,
        DTT_KIND_IMM = 2'h1,
        DTT_KIND_REG = 2'h2,
        DTT_KIND_OVF = 2'h3
    } dtt_kind_t;

    typedef enum logic [1:0] {
        DTT_POL_RING  = 2'h0,
        DTT_POL_STOP  = 2'h1,
        DTT_POL_BREAK = 2'h2
    } dtt_policy_t;

    typedef enum logic [2:0] {
        DTT_TRG_RISE = 3'h0,
        DTT_TRG_FALL = 3'h1,
        DTT_TRG_BOTH = 3'h2,
        DTT_TRG_LOW  = 3'h3,
        DTT_TRG_HIGH = 3'h4
    } dtt_trg_mode_t;

    // Gray sequence idle -> recording -> full
    typedef enum logic [1:0] {
        DTT_ST_IDLE = 2'b00,
        DTT_ST_REC  = 2'b01,
        DTT_ST_FULL = 2'b11
    } dtt_state_t;
endpackage
`default_nettype wire

//--- dtt_trig_det.sv
// Edge or level detector for one external trigger input
`timescale 1ns/100ps
`default_nettype none
module dtt_trig_det import dtt_pkg::*; (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       pin,
    input  wire logic       en,
    input  wire logic [2:0] mode,
    output logic            hit
);
    logic prev_q, prev_d, hit_q, hit_d;

    // Compare with last sample; level modes request every cycle they hold
    always_comb begin
        prev_d = pin;
        case (dtt_trg_mode_t'(mode))
            DTT_TRG_RISE: hit_d = pin & ~prev_q;
            DTT_TRG_FALL: hit_d = ~pin & prev_q;
            DTT_TRG_BOTH: hit_d = pin ^ prev_q;
            DTT_TRG_LOW:  hit_d = ~pin;
            DTT_TRG_HIGH: hit_d = pin;
            default:      hit_d = 1'b0;
        endcase
        hit_d = hit_d & en;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
            hit_q  <= 1'b0;
        end else begin
            prev_q <= prev_d;
            hit_q  <= hit_d;
        end
    end

    assign hit = hit_q;

    rise_hit_a: assert property (@(posedge clk) disable iff (!rst_n)
        (en && mode == DTT_TRG_RISE && pin && !prev_q) |=> hit)
        else $error("rising edge not detected");
endmodule
`default_nettype wire

//--- dtt_pulse_gen.sv
// Trigger output pulse of programmable polarity and width in microsecond ticks
`timescale 1ns/100ps
`default_nettype none
module dtt_pulse_gen import dtt_pkg::*; (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        fire,
    input  wire logic        en,
    input  wire logic        pol,
    input  wire logic [15:0] width,
    output logic             pin_out
);
    localparam logic [6:0] PRE_LAST = 7'(US_CYC - 1);
    logic        act_q, act_d, out_q, out_d;
    logic [6:0]  pre_q, pre_d;
    logic [15:0] wcnt_q, wcnt_d;

    // A zero width is refused so a bad setting never yields an endless pulse
    always_comb begin
        act_d  = act_q;
        pre_d  = pre_q;
        wcnt_d = wcnt_q;
        if (!act_q) begin
            if (fire && en && width != 16'h0000) begin
                act_d  = 1'b1;
                pre_d  = 7'h00;
                wcnt_d = width;
            end
        end else if (pre_q == PRE_LAST) begin
            pre_d  = 7'h00;
            wcnt_d = wcnt_q - 16'h0001;
            if (wcnt_q == 16'h0001) begin
                act_d = 1'b0;
            end
        end else begin
            pre_d = pre_q + 7'h01;
        end
        out_d = act_d ? pol : ~pol;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            act_q  <= 1'b0;
            out_q  <= 1'b0;
            pre_q  <= 7'h00;
            wcnt_q <= 16'h0000;
        end else begin
            act_q  <= act_d;
            out_q  <= out_d;
            pre_q  <= pre_d;
            wcnt_q <= wcnt_d;
        end
    end

    assign pin_out = out_q;

    zero_width_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!act_q && width == 16'h0000) |=> !act_q)
        else $error("pulse started with zero width");
    one_us_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!act_q && fire && en && width == 16'h0001) |=> act_q [*8] ##117 act_q ##1 !act_q)
        else $error("one microsecond pulse has wrong length");
endmodule
`default_nettype wire

//--- dtt_unit.sv
// Trace capture queue, timestamping, recording policy and external triggers of the probe
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - one queue stage per trace record
// - seventh stage full puts overflow record eighth
// - timestamp every record, 8.333 ns, 27 days
// - timestamp at probe receipt time
// - timestamp runs before target may start
// - record from run start until break
// - ring, full-stop or full-break storage policy
// - real-time capture, link never stalled
// - two trigger inputs, two trigger outputs
// - inputs detect rise, fall, both, low, high
// - input breaks, or stops recording when idle
// - break gives output pulse, polarity, width
// - no break detect 10 us after run while trace capture is off
// - block accesses while trace or triggers used
// - target holds 32-bit startup value
// - execution time counts debug link ticks
// - monitor only general local RAM addresses
module dtt_unit import dtt_pkg::*; (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [31:0]        reg_rdata,
    input  wire logic               rec_valid,
    input  wire logic [1:0]         rec_kind,
    input  wire logic [31:0]        rec_pc,
    input  wire logic [31:0]        rec_val,
    input  wire logic               link_tick,
    input  wire logic               target_running,
    input  wire logic               target_break,
    output logic                    run_allow,
    output logic                    periph_break_en,
    output logic      [31:0]        startup_word,
    output logic                    break_req,
    output logic                    trace_stop,
    output logic                    access_block,
    output logic                    mon_req,
    output logic      [31:0]        mon_addr,
    input  wire logic [1:0]         trig_in,
    output logic      [1:0]         trig_out,
    output logic                    mem_valid,
    input  wire logic               mem_ready,
    output logic      [MEM_AW-1:0]  mem_addr,
    output logic      [ENTRY_W-1:0] mem_data
);
    // Register file state
    logic [31:0] ctrl_q, ctrl_d, tcfg_q, tcfg_d, pw_q, pw_d, start_q, start_d;
    logic [31:0] rdata_q, rdata_d, mon_addr_q, mon_addr_d, exec_q, exec_d;
    logic        ovf_q, ovf_d, monerr_q, monerr_d, monreq_q, monreq_d;
    // Control path state
    dtt_state_t  st_q, st_d;
    logic        run_q, brk_q, stop_q, stop_d, brkreq_q, brkreq_d;
    logic [10:0] supp_q, supp_d;
    logic [13:0] acc_q, acc_d;
    logic [TS_W-1:0] ts_q, ts_d;
    logic        tsrun_q;
    // Queue state
    logic [ENTRY_W-1:0] q_mem_q [QDEPTH];
    logic [ENTRY_W-1:0] q_mem_d [QDEPTH];
    logic [2:0]  wp_q, wp_d, rp_q, rp_d;
    logic [3:0]  cnt_q, cnt_d;
    logic        ov_q, ov_d;
    logic [ENTRY_W-1:0] od_q, od_d;
    logic [MEM_AW-1:0]  ma_q, ma_d;

    logic        capture_en, recording, run_rise, brk_rise, brk_det, full_evt;
    logic        push, push_ovf, pop, accept, discard, trig_brk, trig_stop, wr_status;
    logic [1:0]  hit, tin_en, tin_stop, tout_en, tout_pol;
    dtt_policy_t policy;

    assign capture_en = ctrl_q[CTRL_CAP];
    assign policy     = dtt_policy_t'(ctrl_q[CTRL_POL_LO+1:CTRL_POL_LO]);
    assign recording  = (st_q == DTT_ST_REC);
    assign run_rise   = target_running & ~run_q;
    assign brk_rise   = target_break & ~brk_q;
    assign brk_det    = brk_rise & (capture_en | supp_q == 11'h000);
    assign wr_status  = reg_wr && reg_addr == OFS_STATUS;

    // Two trigger inputs and two pulse outputs
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_trig
            assign tin_en[gi]   = tcfg_q[TCFG_IN_EN + gi*TCFG_STRIDE];
            assign tin_stop[gi] = tcfg_q[TCFG_ACT_STOP + gi*TCFG_STRIDE];
            assign tout_en[gi]  = tcfg_q[TCFG_OUT_EN + gi*TCFG_OSTRIDE];
            assign tout_pol[gi] = tcfg_q[TCFG_OUT_POL + gi*TCFG_OSTRIDE];
            dtt_trig_det u_det (
                .clk   (clk),
                .rst_n (rst_n),
                .pin   (trig_in[gi]),
                .en    (tin_en[gi]),
                .mode  (tcfg_q[TCFG_MODE_LO + gi*TCFG_STRIDE +: 3]),
                .hit   (hit[gi])
            );
            dtt_pulse_gen u_pulse (
                .clk     (clk),
                .rst_n   (rst_n),
                .fire    (brk_det),
                .en      (tout_en[gi]),
                .pol     (tout_pol[gi]),
                .width   (pw_q[gi*16 +: 16]),
                .pin_out (trig_out[gi])
            );
        end
    endgenerate

    // Trace capture always breaks; otherwise the per-channel action decides
    assign trig_brk  = |(hit & ({2{capture_en}} | ~tin_stop));
    assign trig_stop = |(hit & {2{~capture_en}} & tin_stop);

    // Register writes, read mux and the software side effects
    always_comb begin
        ctrl_d     = ctrl_q;
        tcfg_d     = tcfg_q;
        pw_d       = pw_q;
        start_d    = start_q;
        mon_addr_d = mon_addr_q;
        monreq_d   = 1'b0;
        monerr_d   = monerr_q & ~(wr_status & reg_wdata[ST_MONERR]);
        ovf_d      = (ovf_q & ~(wr_status & reg_wdata[ST_OVF])) | push_ovf;
        rdata_d    = RST_ZERO;
        exec_d     = run_rise ? RST_ZERO : exec_q + {31'h0, target_running & link_tick};
        if (reg_wr) begin
            case (reg_addr)
                OFS_CTRL:    ctrl_d  = reg_wdata & CTRL_MASK;
                OFS_TCFG:    tcfg_d  = reg_wdata & TCFG_MASK;
                OFS_PWIDTH:  pw_d    = reg_wdata;
                OFS_STARTUP: start_d = reg_wdata;
                OFS_MON: begin
                    // Outside local RAM or while trace or triggers are used: refuse and flag
                    if (reg_wdata >= LRAM_BASE && reg_wdata <= LRAM_LIMIT
                        && !access_block) begin
                        mon_addr_d = reg_wdata;
                        monreq_d   = 1'b1;
                    end else begin
                        monerr_d = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL:    rdata_d = ctrl_q;
                OFS_TCFG:    rdata_d = tcfg_q;
                OFS_PWIDTH:  rdata_d = pw_q;
                OFS_STARTUP: rdata_d = start_q;
                OFS_STATUS: begin
                    rdata_d[ST_REC]    = recording;
                    rdata_d[ST_FULL]   = (st_q == DTT_ST_FULL);
                    rdata_d[ST_OVF]    = ovf_q;
                    rdata_d[ST_MONERR] = monerr_q;
                    rdata_d[ST_TSRUN]  = tsrun_q;
                    rdata_d[ST_CNT_LO +: 4]       = cnt_q;
                    rdata_d[ST_ADDR_LO +: MEM_AW] = ma_q;
                end
                OFS_TS_LO:   rdata_d = ts_q[31:0];
                OFS_TS_HI:   rdata_d = {16'h0000, ts_q[TS_W-1:32]};
                OFS_EXEC:    rdata_d = exec_q;
                OFS_MON:     rdata_d = mon_addr_q;
                default:     rdata_d = RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q     <= RST_ZERO;
            tcfg_q     <= RST_ZERO;
            pw_q       <= RST_PWIDTH;
            start_q    <= RST_ZERO;
            mon_addr_q <= RST_ZERO;
            monreq_q   <= 1'b0;
            monerr_q   <= 1'b0;
            ovf_q      <= 1'b0;
            rdata_q    <= RST_ZERO;
            exec_q     <= RST_ZERO;
        end else begin
            ctrl_q     <= ctrl_d;
            tcfg_q     <= tcfg_d;
            pw_q       <= pw_d;
            start_q    <= start_d;
            mon_addr_q <= mon_addr_d;
            monreq_q   <= monreq_d;
            monerr_q   <= monerr_d;
            ovf_q      <= ovf_d;
            rdata_q    <= rdata_d;
            exec_q     <= exec_d;
        end
    end

    // Timestamp: add 8 ns per clock, tick once per 8.333 ns accumulated
    always_comb begin
        acc_d = 14'h0000;
        ts_d  = '0;
        if (ctrl_q[CTRL_TS]) begin
            acc_d = acc_q + TS_STEP;
            ts_d  = ts_q;
            if (acc_d >= TS_RES) begin
                acc_d = acc_d - TS_RES;
                ts_d  = ts_q + 48'h1;
            end
        end
    end

    // Recording state, break detection window and trigger-driven stop
    always_comb begin
        st_d     = st_q;
        supp_d   = (supp_q != 11'h000) ? supp_q - 11'h001 : supp_q;
        stop_d   = run_rise ? 1'b0 : (stop_q | trig_stop);
        brkreq_d = trig_brk | (full_evt && policy == DTT_POL_BREAK);
        if (run_rise && !capture_en) begin
            supp_d = 11'(SUPP_CYC);
        end
        case (st_q)
            DTT_ST_IDLE: if (run_rise && capture_en) st_d = DTT_ST_REC;
            DTT_ST_REC: begin
                if (full_evt) begin
                    st_d = DTT_ST_FULL;
                end else if (target_break) begin
                    st_d = DTT_ST_IDLE;
                end
            end
            DTT_ST_FULL: if (run_rise) st_d = capture_en ? DTT_ST_REC : DTT_ST_IDLE;
            default: st_d = DTT_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q     <= DTT_ST_IDLE;
            run_q    <= 1'b0;
            brk_q    <= 1'b0;
            stop_q   <= 1'b0;
            brkreq_q <= 1'b0;
            supp_q   <= 11'h000;
            acc_q    <= 14'h0000;
            ts_q     <= '0;
            tsrun_q  <= 1'b0;
        end else begin
            st_q     <= st_d;
            run_q    <= target_running;
            brk_q    <= target_break;
            stop_q   <= stop_d;
            brkreq_q <= brkreq_d;
            supp_q   <= supp_d;
            acc_q    <= acc_d;
            ts_q     <= ts_d;
            tsrun_q  <= ctrl_q[CTRL_TS];
        end
    end

    // Queue never pushes back on the link; a full queue loses records instead
    assign push     = rec_valid && recording && cnt_q < QOVF_LEVEL;
    assign push_ovf = rec_valid && recording && cnt_q == QOVF_LEVEL;
    assign pop      = cnt_q != 4'h0 && (!ov_q || accept || discard);
    assign discard  = ov_q && st_q == DTT_ST_FULL;
    assign accept   = mem_valid && mem_ready;
    assign full_evt = accept && ma_q == MEM_LAST && policy != DTT_POL_RING;

    always_comb begin
        q_mem_d = q_mem_q;
        wp_d    = wp_q;
        rp_d    = rp_q;
        cnt_d   = cnt_q;
        ov_d    = ov_q;
        od_d    = od_q;
        ma_d    = ma_q;
        if (push || push_ovf) begin
            // Whole record plus receive time in a single stage
            q_mem_d[wp_q] = push ? {rec_kind, rec_pc, rec_val, ts_q}
                                 : {DTT_KIND_OVF, 32'h0, 32'h0, ts_q};
            wp_d  = wp_q + 3'h1;
            cnt_d = cnt_d + 4'h1;
        end
        if (accept || discard) begin
            ov_d = 1'b0;
        end
        if (accept) begin
            ma_d = ma_q + 10'h001;
        end
        if (pop) begin
            od_d  = q_mem_q[rp_q];
            ov_d  = 1'b1;
            rp_d  = rp_q + 3'h1;
            cnt_d = cnt_d - 4'h1;
        end
        if (run_rise && st_q == DTT_ST_FULL) begin
            ma_d = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < QDEPTH; i++) begin
                q_mem_q[i] <= '0;
            end
            wp_q  <= 3'h0;
            rp_q  <= 3'h0;
            cnt_q <= 4'h0;
            ov_q  <= 1'b0;
            od_q  <= '0;
            ma_q  <= '0;
        end else begin
            q_mem_q <= q_mem_d;
            wp_q    <= wp_d;
            rp_q    <= rp_d;
            cnt_q   <= cnt_d;
            ov_q    <= ov_d;
            od_q    <= od_d;
            ma_q    <= ma_d;
        end
    end

    // Outputs
    assign mem_valid       = ov_q && st_q != DTT_ST_FULL;
    assign mem_addr        = ma_q;
    assign mem_data        = od_q;
    assign reg_rdata       = rdata_q;
    assign run_allow       = ctrl_q[CTRL_RUN] & ctrl_q[CTRL_TS] & tsrun_q;
    assign periph_break_en = ctrl_q[CTRL_PBRK];
    assign startup_word    = start_q;
    assign break_req       = brkreq_q;
    assign trace_stop      = stop_q;
    assign access_block    = capture_en | (|tin_en) | (|tout_en);
    assign mon_req         = monreq_q;
    assign mon_addr        = mon_addr_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence seven_held_s;
        rec_valid && recording && cnt_q == QOVF_LEVEL && !pop;
    endsequence
    queue_bound_a: assert property (cnt_q <= QFULL)
        else $error("queue count above eight");
    ovf_mark_a: assert property (seven_held_s |=> cnt_q == QFULL
        && q_mem_q[$past(wp_q)][ENTRY_W-1 -: 2] == DTT_KIND_OVF)
        else $error("overflow record missing in eighth stage");
    ts_stamp_a: assert property (push |=> q_mem_q[$past(wp_q)][TS_W-1:0] == $past(ts_q))
        else $error("record not stamped with receive time");
    ts_tick_a: assert property (ctrl_q[CTRL_TS] [*3] |-> ts_q != $past(ts_q, 2))
        else $error("timestamp stalled");
    run_gate_a: assert property (run_allow |-> tsrun_q && ts_q != '0 || acc_q != 14'h0)
        else $error("run allowed before timestamp runs");
    rec_end_a: assert property ((recording && target_break && !full_evt) |=> !recording)
        else $error("recording continued after break");
    suppress_a: assert property ((run_rise && !capture_en) ##1 (brk_rise && !capture_en)
        |-> !brk_det)
        else $error("break detected inside suppression window");
    mon_range_a: assert property (mon_req |-> mon_addr >= LRAM_BASE && mon_addr <= LRAM_LIMIT
        && !$past(access_block))
        else $error("monitor request outside local RAM");
endmodule
`default_nettype wire

//--- dtt_tgt_model.sv
// Behavioural target debug unit on the far side of the trace link
`timescale 1ns/100ps
`default_nettype none
module dtt_tgt_model import dtt_pkg::*; (
    input  wire logic        clk,
    input  wire logic        probe_on,
    output logic             rec_valid,
    output logic      [1:0]  rec_kind,
    output logic      [31:0] rec_pc,
    output logic      [31:0] rec_val,
    output logic             link_tick,
    output logic             target_running,
    output logic             target_break
);
    // Back to back records, the worst case for the probe queue
    task automatic send(input int n);
        repeat (n) begin
            @(posedge clk);
            rec_valid <= probe_on;
            rec_kind  <= 2'($urandom_range(2));
            rec_pc    <= $urandom;
            rec_val   <= $urandom;
        end
        @(posedge clk);
        rec_valid <= 1'b0;
    endtask
    // Peripherals halt exactly while stopped at a break
    task automatic run(input logic r);
        @(posedge clk);
        target_running <= r;
        target_break   <= ~r;
    endtask
    initial begin
        {rec_valid, rec_kind, rec_pc, rec_val, link_tick, target_running} = '0;
        target_break = 1'b0;
    end
    // Link count ticks at half the probe clock
    always @(posedge clk) link_tick <= ~link_tick;
endmodule
`default_nettype wire

//--- debug_trace_trigger_unit_tb.sv
// Self-checking bench of the trace and trigger unit
`timescale 1ns/100ps
`default_nettype none
module debug_trace_trigger_unit_tb;
    import dtt_pkg::*;
    logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, mem_ready = 0, rd_p = 0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, startup_word, hits = 0, hi = 0, b0;
    logic [1:0] trig_in = '0, trig_out, rec_kind;
    logic [31:0] rec_pc, rec_val, mon_addr;
    logic rec_valid, link_tick, t_run, t_brk, run_allow, break_req, access_block, mem_valid;
    logic pbrk, t_stop, mon_req;
    logic [MEM_AW-1:0] mem_addr;
    logic [ENTRY_W-1:0] mem_data;
    logic [63:0] q[$];
    int fails = 0, tests_run = 0;
    always #4 clk = ~clk;
    dtt_tgt_model u_tgt (.clk(clk), .probe_on(1'b1), .rec_valid(rec_valid),
        .rec_kind(rec_kind), .rec_pc(rec_pc), .rec_val(rec_val), .link_tick(link_tick),
        .target_running(t_run), .target_break(t_brk));
    dtt_unit u_dtt_unit (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rec_valid(rec_valid), .rec_kind(rec_kind), .rec_pc(rec_pc), .rec_val(rec_val),
        .link_tick(link_tick), .target_running(t_run), .target_break(t_brk),
        .run_allow(run_allow), .periph_break_en(pbrk), .startup_word(startup_word),
        .break_req(break_req), .trace_stop(t_stop), .access_block(access_block),
        .mon_req(mon_req), .mon_addr(mon_addr), .trig_in(trig_in), .trig_out(trig_out),
        .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_addr(mem_addr),
        .mem_data(mem_data));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Expected read value and mask are queued for the watcher
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        q.push_back({m, e});
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_p) begin
            chk("reg_rdata", reg_rdata & q[0][63:32], q[0][31:0] & q[0][63:32]);
            q.delete(0);
        end
        // Ninth entry accepted is the overflow mark of the stalled queue
        if (mem_valid && mem_ready && mem_addr == 10'h008)
            chk("ovf kind", 32'(mem_data[ENTRY_W-1 -: 2]), 32'(DTT_KIND_OVF));
        rd_p <= reg_rd;
        hits <= hits + 32'(break_req);
        hi   <= hi + 32'(trig_out[0]);
    end
    initial begin
        #400000;
        fails++;
        stop_test;
    end
    initial begin
        void'($urandom(32'hf909));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_PWIDTH, RST_PWIDTH, '1);
        rd(8'h3c, '0, '1);
        wr(OFS_STARTUP, 32'h5a5a_1234);
        rd(OFS_STARTUP, 32'h5a5a_1234, '1);
        chk("startup_word", startup_word, 32'h5a5a_1234);
        wr(OFS_CTRL, 32'h24);
        repeat (3) @(posedge clk);
        chk("run_allow", run_allow, 0);
        chk("periph_break_en", pbrk, 1);
        // Monitor request stands one cycle after the write
        wr(OFS_MON, 32'h1000_0040);
        @(negedge clk);
        chk("mon_req", mon_req, 1);
        chk("mon_addr", mon_addr, 32'h1000_0040);
        wr(OFS_MON, 32'h2000_0000);
        @(negedge clk);
        chk("mon refused", mon_req, 0);
        rd(OFS_STATUS, 32'h8, 32'h8);
        $display("test registers done");
        // Stop policy, capture and timestamp on, queue stalled
        wr(OFS_CTRL, 32'h0f);
        repeat (3) @(posedge clk);
        chk("run_allow", run_allow, 1);
        chk("access_block", access_block, 1);
        u_tgt.run(1);
        u_tgt.send(10);
        rd(OFS_STATUS, 32'h815, 32'hf17);
        mem_ready <= 1'b1;
        u_tgt.run(0);
        repeat (20) @(posedge clk);
        rd(OFS_STATUS, 32'h0, 32'h3);
        $display("test trace done");
        wr(OFS_CTRL, 32'h0);
        for (int m = 0; m < 5; m++) begin
            // Idle level never triggers; pipeline drained before the baseline
            wr(OFS_TCFG, 32'h8 | m);
            repeat (4) @(posedge clk) trig_in <= {1'b0, m == 3};
            b0 = hits;
            repeat (3) @(posedge clk) trig_in <= {1'b0, m != 3};
            repeat (5) @(posedge clk) trig_in <= {1'b0, m == 3};
            chk("trigger hit", 32'(hits != b0), 1);
        end
        // Channel 1 rising edge stops recording instead of breaking
        wr(OFS_TCFG, 32'h1800);
        b0 = hits;
        repeat (2) @(posedge clk) trig_in <= 2'b10;
        repeat (4) @(posedge clk) trig_in <= 2'b00;
        chk("trace_stop", t_stop, 1);
        chk("stop no break", hits - b0, 0);
        $display("test trigger inputs done");
        // Output pulse, 1 us wide, high polarity
        wr(OFS_TCFG, 32'h0003_0000);
        u_tgt.run(1);
        u_tgt.run(0);
        b0 = hi;
        repeat (20) @(posedge clk);
        chk("suppressed pulse", hi - b0, 0);
        u_tgt.run(1);
        repeat (1300) @(posedge clk);
        b0 = hi;
        u_tgt.run(0);
        repeat (140) @(posedge clk);
        chk("pulse width", hi - b0, 32'(US_CYC));
        $display("test trigger output done");
        stop_test;
    end
endmodule
`default_nettype wire
